// file: tsl_pkg.sv
// constants and state types for the teleprinter serial link
// assumes a single 100 MHz clock and an 11-interval character frame
package tsl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int UNIT_TIME_NS = 9090909;
	localparam int UNIT_CYCLES = UNIT_TIME_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 20;
	localparam int CHAR_W = 8;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] LAST_DATA_CNT = 5'h08;
	localparam logic [CNT_W-1:0] LAST_STOP_CNT = 5'h0A;
	localparam logic [2:0] LAST_RX_BIT = 3'h7;
	localparam int FRAME_UNITS = 11;
	localparam int FIFO_DEPTH = 4;
	localparam logic MARK = 1'b1;
	localparam logic SPACE = 1'b0;
	localparam logic [CHAR_W-1:0] CHAR_RST = 8'h00;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tsl_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tsl_rx_state_t;
endpackage

// file: tsl_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
module tsl_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_in_data,
	input wire logic i_in_valid,
	output logic o_in_ready,
	output logic [W-1:0] o_out_data,
	output logic o_out_valid,
	input wire logic i_out_ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
	endfunction

	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr_ff];
	assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			o_in_ready <= 1'b0;
			o_out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			end
			if (pop) begin
				rd_ptr_ff <= ptr_inc(rd_ptr_ff);
			end
			cnt_ff <= nxt_cnt;
			o_in_ready <= (nxt_cnt != (AW+1)'(D));
			o_out_valid <= (nxt_cnt != '0);
		end
	end

	a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		cnt_ff <= (AW+1)'(D))
		else $error("fifo count above depth");
	c_fifo_full: cover property (@(posedge i_clk) disable iff (!i_rst_b)
		cnt_ff == (AW+1)'(D));
endmodule

// file: tsl_link.sv
// teleprinter serial link: framed send half and receive half
// assumes host logic on the parallel side, terminal line inputs synchronous
// Function
// - take parallel 8-bit character, send serially
// - frame with start and stop signalling
// - pace bits at terminal's character rate
// - pass bits unchanged, no code conversion
// - shift register, 5-bit counter, control state
// - receive one framed 8-bit serial character
// - present received bits in parallel register
// - down-counter timing, control state, shift register
// - receive at terminal's output rate
`timescale 1ns/1ns
module tsl_link #(
	parameter int P_UNIT_CYCLES = tsl_pkg::UNIT_CYCLES
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic [7:0] I_TX_DATA,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	output logic O_TX_SER,
	output logic O_TX_BUSY,
	input wire logic I_RX_SER,
	output logic [7:0] O_RX_DATA,
	output logic O_RX_VALID,
	output logic O_RX_FRAME_ERR
);
	localparam logic [tsl_pkg::DIV_W-1:0] UNIT_LAST = tsl_pkg::DIV_W'(P_UNIT_CYCLES - 1);
	localparam logic [tsl_pkg::DIV_W-1:0] HALF_LAST = tsl_pkg::DIV_W'(P_UNIT_CYCLES / 2 - 1);
	localparam int FRAME_CYC = tsl_pkg::FRAME_UNITS * P_UNIT_CYCLES;

	tsl_pkg::tsl_tx_state_t tx_state_ff;
	tsl_pkg::tsl_rx_state_t rx_state_ff;
	logic [tsl_pkg::CHAR_W-1:0] tx_sh_ff, rx_sh_ff, fifo_data;
	logic [tsl_pkg::CNT_W-1:0] tx_cnt_ff;
	logic [tsl_pkg::DIV_W-1:0] tx_div_ff, rx_clk_ff;
	logic [2:0] rx_bit_ff;
	logic rx_prev_ff, fifo_valid, fifo_take, tx_tick, rx_tick;
	int tx_len_ff;

	function automatic logic at_last(input logic [tsl_pkg::DIV_W-1:0] c,
		input logic [tsl_pkg::DIV_W-1:0] lim);
		at_last = (c == lim);
	endfunction

	tsl_fifo #(
		.W(tsl_pkg::CHAR_W),
		.D(tsl_pkg::FIFO_DEPTH)
	) tsl_fifo_inst (
		.i_clk(I_REF_CLK),
		.i_rst_b(I_RST_B),
		.i_in_data(I_TX_DATA),
		.i_in_valid(I_TX_VALID),
		.o_in_ready(O_TX_READY),
		.o_out_data(fifo_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_take)
	);

	assign fifo_take = (tx_state_ff == tsl_pkg::TX_IDLE);
	assign tx_tick = at_last(tx_div_ff, UNIT_LAST);
	assign rx_tick = at_last(rx_clk_ff, '0);

	// unit interval divider for the send half
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tx_div_ff <= '0;
		end else if (tx_state_ff == tsl_pkg::TX_IDLE || tx_tick) begin
			tx_div_ff <= '0;
		end else begin
			tx_div_ff <= tx_div_ff + 1'b1;
		end
	end

	// send sequencing
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tx_state_ff <= tsl_pkg::TX_IDLE;
			tx_sh_ff <= tsl_pkg::CHAR_RST;
			tx_cnt_ff <= '0;
			O_TX_SER <= tsl_pkg::MARK;
			O_TX_BUSY <= 1'b0;
		end else begin
			case (tx_state_ff)
				tsl_pkg::TX_IDLE: begin
					O_TX_SER <= tsl_pkg::MARK;
					O_TX_BUSY <= fifo_valid;
					if (fifo_valid) begin
						tx_sh_ff <= fifo_data;
						tx_cnt_ff <= '0;
						O_TX_SER <= tsl_pkg::SPACE;
						tx_state_ff <= tsl_pkg::TX_START;
					end
				end
				tsl_pkg::TX_START: begin
					if (tx_tick) begin
						tx_cnt_ff <= tx_cnt_ff + 1'b1;
						O_TX_SER <= tx_sh_ff[0];
						tx_state_ff <= tsl_pkg::TX_DATA;
					end
				end
				tsl_pkg::TX_DATA: begin
					if (tx_tick) begin
						tx_cnt_ff <= tx_cnt_ff + 1'b1;
						if (tx_cnt_ff == tsl_pkg::LAST_DATA_CNT) begin
							O_TX_SER <= tsl_pkg::MARK;
							tx_state_ff <= tsl_pkg::TX_STOP;
						end else begin
							tx_sh_ff <= tx_sh_ff >> 1;
							O_TX_SER <= tx_sh_ff[1];
						end
					end
				end
				tsl_pkg::TX_STOP: begin
					if (tx_tick) begin
						tx_cnt_ff <= tx_cnt_ff + 1'b1;
						if (tx_cnt_ff == tsl_pkg::LAST_STOP_CNT) begin
							tx_state_ff <= tsl_pkg::TX_IDLE;
							O_TX_BUSY <= 1'b0;
						end
					end
				end
				default: begin
					tx_state_ff <= tsl_pkg::TX_IDLE;
					O_TX_SER <= tsl_pkg::MARK;
				end
			endcase
		end
	end

	// previous line level for start edge detection
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rx_prev_ff <= tsl_pkg::MARK;
		end else begin
			rx_prev_ff <= I_RX_SER;
		end
	end

	// receive sequencing
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rx_state_ff <= tsl_pkg::RX_IDLE;
			rx_clk_ff <= '0;
			rx_bit_ff <= '0;
			rx_sh_ff <= tsl_pkg::CHAR_RST;
			O_RX_DATA <= tsl_pkg::CHAR_RST;
			O_RX_VALID <= 1'b0;
			O_RX_FRAME_ERR <= 1'b0;
		end else begin
			O_RX_VALID <= 1'b0;
			O_RX_FRAME_ERR <= 1'b0;
			if (rx_state_ff != tsl_pkg::RX_IDLE && !rx_tick) begin
				rx_clk_ff <= rx_clk_ff - 1'b1;
			end
			case (rx_state_ff)
				tsl_pkg::RX_IDLE: begin
					if (rx_prev_ff == tsl_pkg::MARK && I_RX_SER == tsl_pkg::SPACE) begin
						rx_clk_ff <= HALF_LAST;
						rx_state_ff <= tsl_pkg::RX_START;
					end
				end
				tsl_pkg::RX_START: begin
					if (rx_tick) begin
						rx_clk_ff <= UNIT_LAST;
						rx_bit_ff <= '0;
						rx_state_ff <= (I_RX_SER == tsl_pkg::SPACE) ?
							tsl_pkg::RX_DATA : tsl_pkg::RX_IDLE;
					end
				end
				tsl_pkg::RX_DATA: begin
					if (rx_tick) begin
						rx_clk_ff <= UNIT_LAST;
						rx_sh_ff <= {I_RX_SER, rx_sh_ff[7:1]};
						rx_bit_ff <= rx_bit_ff + 1'b1;
						if (rx_bit_ff == tsl_pkg::LAST_RX_BIT) begin
							rx_state_ff <= tsl_pkg::RX_STOP;
						end
					end
				end
				tsl_pkg::RX_STOP: begin
					if (rx_tick) begin
						rx_state_ff <= tsl_pkg::RX_IDLE;
						if (I_RX_SER == tsl_pkg::MARK) begin
							O_RX_DATA <= rx_sh_ff;
							O_RX_VALID <= 1'b1;
						end else begin
							O_RX_FRAME_ERR <= 1'b1;
						end
					end
				end
				default: begin
					rx_state_ff <= tsl_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// frame length helper for checks
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tx_len_ff <= 0;
		end else if (tx_state_ff == tsl_pkg::TX_IDLE) begin
			tx_len_ff <= 0;
		end else begin
			tx_len_ff <= tx_len_ff + 1;
		end
	end

	a_tx_idle_mark: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		tx_state_ff == tsl_pkg::TX_IDLE |-> O_TX_SER == tsl_pkg::MARK)
		else $error("line not at mark while idle");
	a_tx_start_space: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		tx_state_ff == tsl_pkg::TX_START |-> O_TX_SER == tsl_pkg::SPACE)
		else $error("start interval not at space");
	a_tx_stop_mark: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		tx_state_ff == tsl_pkg::TX_STOP |-> O_TX_SER == tsl_pkg::MARK)
		else $error("stop interval not at mark");
	a_tx_data_bit: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		tx_state_ff == tsl_pkg::TX_DATA |-> O_TX_SER == tx_sh_ff[0])
		else $error("data bit differs from shift register");
	a_tx_take_char: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		tx_state_ff == tsl_pkg::TX_IDLE && fifo_valid |=>
		tx_state_ff == tsl_pkg::TX_START && tx_sh_ff == $past(fifo_data))
		else $error("character not taken");
	a_tx_shift_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		tx_state_ff == tsl_pkg::TX_DATA && !tx_tick |=> $stable(tx_sh_ff) && $stable(O_TX_SER))
		else $error("send shifted between ticks");
	a_tx_frame_len: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		$past(tx_state_ff) != tsl_pkg::TX_IDLE && tx_state_ff == tsl_pkg::TX_IDLE |->
		tx_len_ff == FRAME_CYC)
		else $error("frame length is not eleven units");
	a_rx_start_edge: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		rx_state_ff == tsl_pkg::RX_IDLE && rx_prev_ff && !I_RX_SER |=>
		rx_state_ff == tsl_pkg::RX_START && rx_clk_ff == HALF_LAST)
		else $error("start edge missed");
	a_rx_false_start: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		rx_state_ff == tsl_pkg::RX_START && rx_tick && I_RX_SER |=>
		rx_state_ff == tsl_pkg::RX_IDLE)
		else $error("false start accepted");
	a_rx_valid_pulse: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		O_RX_VALID |=> !O_RX_VALID)
		else $error("receive valid longer than one cycle");
	a_rx_data_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		!O_RX_VALID |-> $stable(O_RX_DATA))
		else $error("received data changed without valid");
	a_rx_bit_shift: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		rx_state_ff == tsl_pkg::RX_DATA && rx_tick |=> rx_sh_ff[7] == $past(I_RX_SER))
		else $error("sampled bit not shifted in");

	c_tx_frame: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		tx_state_ff == tsl_pkg::TX_STOP ##1 tx_state_ff == tsl_pkg::TX_IDLE);
	c_rx_char: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B) O_RX_VALID);
	c_rx_frame_err: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B) O_RX_FRAME_ERR);
	c_tx_backpressure: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		I_TX_VALID && !O_TX_READY);
endmodule

// file: tsl_term_model.sv
// keyboard-printer terminal model on the serial side of the link
// assumes one clock and a unit interval of P clock cycles, line idles at mark
`timescale 1ns/1ns
module tsl_term_model #(
	parameter int P = 8
) (
	input wire logic i_clk,
	input wire logic i_line_in,
	output logic o_line_out
);
	logic [7:0] got_q[$];
	logic stop_ok_q[$];
	initial o_line_out = 1'b1;
	// start, eight data lsb first, two stop
	task automatic send(input logic [7:0] ch, input logic stop_lvl);
		logic [10:0] fr;
		fr = {{2{stop_lvl}}, ch, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(negedge i_clk);
			o_line_out = fr[i];
			repeat (P - 1) @(negedge i_clk);
		end
		@(negedge i_clk);
		o_line_out = 1'b1;
	endtask
	// short space pulse, not a start
	task automatic glitch();
		@(negedge i_clk);
		o_line_out = 1'b0;
		repeat (2) @(negedge i_clk);
		o_line_out = 1'b1;
	endtask
	// mid-interval sampling of frames from the link
	initial begin
		logic [7:0] d;
		logic ok;
		forever begin
			@(negedge i_line_in);
			repeat (P / 2) @(posedge i_clk);
			if (i_line_in === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (P) @(posedge i_clk);
					d[i] = i_line_in;
				end
				repeat (P) @(posedge i_clk);
				ok = i_line_in;
				repeat (P) @(posedge i_clk);
				ok = ok & i_line_in;
				got_q.push_back(d);
				stop_ok_q.push_back(ok);
			end
		end
	end
endmodule

// file: testbench.sv
// self-checking bench for the serial link against a terminal model
// assumes short unit interval parameter, 100 MHz clock
`timescale 1ns/1ns
module testbench;
	localparam int P = 8;
	logic clk;
	logic rst_b;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	logic tx_ser;
	logic tx_busy;
	logic rx_ser;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_ferr;
	int mismatches;
	int checks_done;
	int ferr_cnt;
	logic [7:0] rx_q[$];
	tsl_link #(.P_UNIT_CYCLES(P)) tsl_link_inst (
		.I_REF_CLK(clk),
		.I_RST_B(rst_b),
		.I_TX_DATA(tx_data),
		.I_TX_VALID(tx_valid),
		.O_TX_READY(tx_ready),
		.O_TX_SER(tx_ser),
		.O_TX_BUSY(tx_busy),
		.I_RX_SER(rx_ser),
		.O_RX_DATA(rx_data),
		.O_RX_VALID(rx_valid),
		.O_RX_FRAME_ERR(rx_ferr)
	);
	tsl_term_model #(.P(P)) tsl_term_model_inst (
		.i_clk(clk),
		.i_line_in(tx_ser),
		.o_line_out(rx_ser)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// capture receive pulses
	always @(posedge clk) begin
		if (rx_valid === 1'b1)
			rx_q.push_back(rx_data);
		if (rx_ferr === 1'b1)
			ferr_cnt++;
	end
	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_reset();
		@(negedge clk);
		chk(tx_ser === 1'b1 && tx_busy === 1'b0, "line not idle at mark");
		chk(rx_data === 8'h00 && rx_valid === 1'b0, "receive not cleared");
		chk(tx_ready === 1'b1, "send not ready");
		$display("test reset done");
	endtask
	task automatic t_send_burst();
		logic [7:0] ch[5] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h81};
		logic acc;
		int k;
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			tx_data = ch[i];
			tx_valid = 1'b1;
			acc = 1'b0;
			for (k = 0; k < 2000 && !acc; k++) begin
				@(posedge clk);
				acc = tx_ready;
			end
		end
		@(negedge clk);
		tx_valid = 1'b0;
		chk(tx_ready === 1'b0, "fifo full not refused");
		chk(tx_busy === 1'b1, "busy low in frame");
		for (k = 0; k < 60 * P && tsl_term_model_inst.got_q.size() < 5; k++)
			@(negedge clk);
		chk(tsl_term_model_inst.got_q.size() == 5, "frame count");
		for (int i = 0; i < 5 && tsl_term_model_inst.got_q.size() > 0; i++) begin
			chk(tsl_term_model_inst.got_q.pop_front() === ch[i], "sent data");
			chk(tsl_term_model_inst.stop_ok_q.pop_front() === 1'b1, "stop");
		end
		repeat (2 * P) @(negedge clk);
		chk(tx_busy === 1'b0 && tx_ser === 1'b1, "not idle after");
		$display("test send_burst done");
	endtask
	task automatic t_recv();
		tsl_term_model_inst.send(8'h3C, 1'b1);
		tsl_term_model_inst.send(8'hC3, 1'b1);
		repeat (P) @(negedge clk);
		chk(rx_q.size() == 2, "receive count");
		if (rx_q.size() == 2) begin
			chk(rx_q[0] === 8'h3C, "first char");
			chk(rx_q[1] === 8'hC3, "second char");
		end
		rx_q.delete();
		$display("test recv done");
	endtask
	task automatic t_frame_err();
		int f;
		f = ferr_cnt;
		tsl_term_model_inst.send(8'h55, 1'b0);
		repeat (P) @(negedge clk);
		chk(ferr_cnt == f + 1, "no frame error");
		chk(rx_q.size() == 0 && rx_data === 8'hC3, "bad char kept");
		$display("test frame_err done");
	endtask
	task automatic t_glitch();
		int f;
		f = ferr_cnt;
		tsl_term_model_inst.glitch();
		repeat (12 * P) @(negedge clk);
		chk(rx_q.size() == 0 && ferr_cnt == f, "glitch taken");
		tsl_term_model_inst.send(8'h96, 1'b1);
		repeat (P) @(negedge clk);
		chk(rx_q.size() == 1 && rx_data === 8'h96, "no rearm");
		rx_q.delete();
		$display("test glitch done");
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		mismatches = 0;
		checks_done = 0;
		ferr_cnt = 0;
		rst_b = 1'b0;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		t_reset();
		t_send_burst();
		t_recv();
		t_frame_err();
		t_glitch();
		tally_and_finish();
	end
endmodule
